/* design/ptc_pkg.sv */
// Purpose: Constants, types and the input edge detector of the capture timer.
// Assumes: One clock; capture and clock pins are synchronous to clk.
// Notes: Register map and field layout live here.
// Behaviour
// - Operating mode field value 01 selects capture input mode.
// - Capture source bit selects capture pin or external clock pin.
// - Pin function field picks rising, falling or both edges.
// - Pin function 11 disables capture while the counter keeps running.
// - In capture mode counting starts on a rising counter run bit.
// - Active edge copies the counter into compare/capture A and interrupts.
// - Counter runs through captures and stops only when run falls.
// - Period match resets the counter to zero and sets the period flag.
// - Period value zero lets the counter run its full range.
// - Capture mode ignores clear source, initial level and invert; no output.
// - Match A flag is set one clock after the capture latch.
// - Capture latch follows the active edge within 1.5 timer clocks; the design latches on the third clock edge after the pin edge.
// - Single pulse mode: external clock pin edge sets the run bit.
// - Single pulse mode: compare A match clears the run bit.
// - Counter is ten bits wide with maximum 3ff.

`timescale 1ns/1ps
`default_nettype none

package ptc_pkg;
    localparam int CNT_W  = 10;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int FLAG_W = 2;
    localparam int PIN_N  = 2;

    localparam logic [CNT_W-1:0] CNT_MAX  = 10'h3ff;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;

    localparam logic [ADDR_W-1:0] ADDR_RUN    = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_COMPARE_CAPTURE_A   = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_COUNT  = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h6;

    localparam int BIT_RUN    = 0;
    localparam int BIT_CLKSEL = 1;
    localparam int FLAG_A     = 0;
    localparam int FLAG_P     = 1;
    localparam int PIN_CAP    = 0;
    localparam int PIN_EXT    = 1;

    localparam int FLAG_DELAY_CYC = 1;
    localparam int LATCH_MAX_CYC  = 1;

    localparam logic [FLAG_W-1:0] FLAG_RST = 2'h0;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM     = 2'b10,
        MODE_TIMER   = 2'b11
    } ptc_mode_t;

    typedef enum logic [1:0] {
        PF_RISE = 2'b00,
        PF_FALL = 2'b01,
        PF_BOTH = 2'b10,
        PF_NONE = 2'b11
    } ptc_pinfunc_t;

    // Layout of timer_control_1, msb first.
    typedef struct packed {
        ptc_mode_t    opMode;
        ptc_pinfunc_t pinFunc;
        logic         outputInitialLevel;
        logic         outputInvert;
        logic         captureSourceSel;
        logic         clearSourceSel;
    } ptc_ctrl_t;

    localparam ptc_ctrl_t CTRL_RST = 8'h00;

    typedef struct packed {
        logic rise;
        logic fall;
    } ptc_edge_t;
endpackage : ptc_pkg

module ptc_edge_detect
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          pinIn,
    output ptc_pkg::ptc_edge_t edges
);
    import ptc_pkg::*;

    logic syncA_ff;
    logic syncB_ff;
    logic prev_ff;

    // Two-flop synchroniser, then compare with the previous sample.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            syncA_ff <= 1'b0;
            syncB_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end
        else
        begin
            syncA_ff <= pinIn;
            syncB_ff <= syncA_ff;
            prev_ff  <= syncB_ff;
        end
    end

    assign edges = '{rise: syncB_ff & ~prev_ff, fall: ~syncB_ff & prev_ff};
endmodule : ptc_edge_detect

`default_nettype wire

/* design/ptc_capture_timer.sv */
// Purpose: Ten-bit periodic timer with capture, compare, PWM and single pulse.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes: Status bits clear on read; a hardware set in the same cycle wins.

`timescale 1ns/1ps
`default_nettype none

module ptc_capture_timer
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [ptc_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [ptc_pkg::DATA_W-1:0] regWdata,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output logic      [ptc_pkg::DATA_W-1:0] regRdata,
    input  wire logic                       capturePin,
    input  wire logic                       extClockPin,
    output logic                            timerOut,
    output logic                            irq
);
    import ptc_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    ptc_ctrl_t              ctrl_ff;
    logic                   run_ff;
    logic                   runDly_ff;
    logic                   clkSel_ff;
    logic [CNT_W-1:0]       period_ff;
    logic [CNT_W-1:0]       compare_capture_a_ff;
    logic [CNT_W-1:0]       count_ff;
    logic [FLAG_W-1:0]      status_ff;
    logic [FLAG_W-1:0]      mask_ff;
    logic                   capDly_ff;
    logic                   level_ff;
    logic [DATA_W-1:0]      regRdata_ff;
    logic                   timerOut_ff;
    logic                   irq_ff;

    ptc_edge_t              pinEdges [PIN_N];
    logic      [PIN_N-1:0]  pinRaw;
    ptc_edge_t              capEdge;
    logic                   tick;
    logic                   runRise;
    logic                   spMode;
    logic                   clrByA;
    logic [CNT_W-1:0]       periodTop;
    logic                   matchP;
    logic                   matchA;
    logic                   capEvt;
    logic                   wrRun;
    logic [FLAG_W-1:0]      flagSet;

    // Decides whether an edge pair hits the selected transition type.
    function automatic logic edgeHit(input ptc_pinfunc_t pf, input ptc_edge_t e);
        logic hit;
        hit = 1'b0;
        unique case (pf)
            PF_RISE: hit = e.rise;
            PF_FALL: hit = e.fall;
            PF_BOTH: hit = e.rise | e.fall;
            PF_NONE: hit = 1'b0;
        endcase
        return hit;
    endfunction : edgeHit

    ////////////////////////////////////////////////////////////////////////

    assign pinRaw[PIN_CAP] = capturePin;
    assign pinRaw[PIN_EXT] = extClockPin;

    // One synchronising edge detector per input pin.
    generate
        for (genvar gi = 0; gi < PIN_N; gi++)
        begin : g_pin
            ptc_edge_detect u_edge
            (
                .clk   (clk),
                .rst   (rst),
                .pinIn (pinRaw[gi]),
                .edges (pinEdges[gi])
            );
        end
    endgenerate

    assign capEdge   = ctrl_ff.captureSourceSel ? pinEdges[PIN_EXT] : pinEdges[PIN_CAP];
    assign tick      = clkSel_ff ? pinEdges[PIN_EXT].rise : 1'b1;
    assign runRise   = run_ff & ~runDly_ff;
    assign spMode    = (ctrl_ff.opMode == MODE_PWM) && (ctrl_ff.pinFunc == PF_NONE);
    assign clrByA    = ctrl_ff.clearSourceSel
                     && ((ctrl_ff.opMode == MODE_COMPARE) || (ctrl_ff.opMode == MODE_TIMER));
    assign periodTop = (period_ff == CNT_ZERO) ? CNT_MAX : period_ff;
    assign matchP    = run_ff && tick && !runRise && !spMode && (count_ff == periodTop);
    assign matchA    = run_ff && tick && !runRise && (ctrl_ff.opMode != MODE_CAPTURE)
                     && (count_ff == compare_capture_a_ff);
    assign capEvt    = (ctrl_ff.opMode == MODE_CAPTURE) && edgeHit(ctrl_ff.pinFunc, capEdge);
    assign wrRun     = regWr && (regAddr == ADDR_RUN);

    ////////////////////////////////////////////////////////////////////////

    // Software control registers.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_ff   <= CTRL_RST;
            clkSel_ff <= 1'b0;
            period_ff <= CNT_ZERO;
            mask_ff   <= FLAG_RST;
        end
        else if (regWr)
        begin
            unique case (regAddr)
                ADDR_RUN:    clkSel_ff <= regWdata[BIT_CLKSEL];
                ADDR_CTRL1:  ctrl_ff   <= regWdata[$bits(ptc_ctrl_t)-1:0];
                ADDR_PERIOD: period_ff <= regWdata[CNT_W-1:0];
                ADDR_MASK:   mask_ff   <= regWdata[FLAG_W-1:0];
                default:     mask_ff   <= mask_ff;
            endcase
        end
    end

    // Run bit: software write, single pulse start by pin and stop by match.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            run_ff    <= 1'b0;
            runDly_ff <= 1'b0;
        end
        else
        begin
            runDly_ff <= run_ff;
            if (wrRun)
                run_ff <= regWdata[BIT_RUN];
            else if (spMode && matchA)
                run_ff <= 1'b0;
            else if (spMode && pinEdges[PIN_EXT].rise)
                run_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Counter: cleared on run rise, held while run is low.
    always_ff @(posedge clk)
    begin
        if (rst)
            count_ff <= CNT_ZERO;
        else if (runRise)
            count_ff <= CNT_ZERO;
        else if (run_ff && tick)
        begin
            if (matchP && !clrByA)
                count_ff <= CNT_ZERO;
            else if (matchA && clrByA)
                count_ff <= CNT_ZERO;
            else
                count_ff <= count_ff + CNT_ONE;
        end
    end

    // Compare/capture A: captured counter value or software write.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            compare_capture_a_ff   <= CNT_ZERO;
            capDly_ff <= 1'b0;
        end
        else
        begin
            capDly_ff <= capEvt;
            if (capEvt)
                compare_capture_a_ff <= count_ff;
            else if (regWr && (regAddr == ADDR_COMPARE_CAPTURE_A))
                compare_capture_a_ff <= regWdata[CNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        flagSet         = FLAG_RST;
        flagSet[FLAG_A] = capDly_ff
                        || (matchA && ((compare_capture_a_ff != CNT_ZERO) || (ctrl_ff.opMode == MODE_PWM)));
        flagSet[FLAG_P] = matchP && !clrByA;
    end

    // Sticky status cleared by a read; a set in the same cycle wins.
    always_ff @(posedge clk)
    begin
        if (rst)
            status_ff <= FLAG_RST;
        else if (regRd && (regAddr == ADDR_STATUS))
            status_ff <= flagSet;
        else
            status_ff <= status_ff | flagSet;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(status_ff & mask_ff);
    end

    ////////////////////////////////////////////////////////////////////////

    // Compare output level: initial value on run rise, action on match A.
    always_ff @(posedge clk)
    begin
        if (rst)
            level_ff <= 1'b0;
        else if (runRise)
            level_ff <= ctrl_ff.outputInitialLevel;
        else if (matchA && (compare_capture_a_ff != CNT_ZERO))
        begin
            unique case (ctrl_ff.pinFunc)
                PF_RISE: level_ff <= level_ff;
                PF_FALL: level_ff <= 1'b0;
                PF_BOTH: level_ff <= 1'b1;
                PF_NONE: level_ff <= ~level_ff;
            endcase
        end
    end

    // Output waveform; capture and timer modes drive nothing.
    always_ff @(posedge clk)
    begin
        if (rst)
            timerOut_ff <= 1'b0;
        else
        begin
            unique case (ctrl_ff.opMode)
                MODE_COMPARE: timerOut_ff <= level_ff ^ ctrl_ff.outputInvert;
                MODE_PWM:
                begin
                    if (spMode)
                        timerOut_ff <= run_ff ^ ctrl_ff.outputInvert;
                    else if (ctrl_ff.pinFunc == PF_BOTH)
                        timerOut_ff <= (count_ff < compare_capture_a_ff) ^ ctrl_ff.outputInvert;
                    else
                        timerOut_ff <= ctrl_ff.pinFunc[0] ^ ctrl_ff.outputInvert;
                end
                MODE_CAPTURE: timerOut_ff <= 1'b0;
                MODE_TIMER:   timerOut_ff <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Read data in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk)
    begin
        if (rst)
            regRdata_ff <= '0;
        else if (regRd)
        begin
            unique case (regAddr)
                ADDR_RUN:    regRdata_ff <= DATA_W'({clkSel_ff, run_ff});
                ADDR_CTRL1:  regRdata_ff <= DATA_W'(ctrl_ff);
                ADDR_PERIOD: regRdata_ff <= DATA_W'(period_ff);
                ADDR_COMPARE_CAPTURE_A:   regRdata_ff <= DATA_W'(compare_capture_a_ff);
                ADDR_COUNT:  regRdata_ff <= DATA_W'(count_ff);
                ADDR_STATUS: regRdata_ff <= DATA_W'(status_ff);
                ADDR_MASK:   regRdata_ff <= DATA_W'(mask_ff);
                default:     regRdata_ff <= '0;
            endcase
        end
        else
            regRdata_ff <= '0;
    end

    assign regRdata = regRdata_ff;
    assign timerOut = timerOut_ff;
    assign irq      = irq_ff;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_capture_latch: assert property (capEvt |=> compare_capture_a_ff == $past(count_ff))
        else $error("Capture did not latch the counter.");

    a_latch_delay: assert property (
        (ctrl_ff.opMode == MODE_CAPTURE) && !ctrl_ff.captureSourceSel
        && (ctrl_ff.pinFunc == PF_RISE) && pinEdges[PIN_CAP].rise
        |=> compare_capture_a_ff == $past(count_ff))
        else $error("Capture latch came late.");

    a_flag_delay: assert property (capEvt |=> ##1 status_ff[FLAG_A])
        else $error("Match A flag not set one cycle after capture.");

    a_no_capture: assert property (
        (ctrl_ff.opMode == MODE_CAPTURE) && (ctrl_ff.pinFunc == PF_NONE)
        && !(regWr && (regAddr == ADDR_COMPARE_CAPTURE_A)) |=> compare_capture_a_ff == $past(compare_capture_a_ff))
        else $error("Capture happened with edges disabled.");

    a_source_sel: assert property (
        (ctrl_ff.opMode == MODE_CAPTURE) && ctrl_ff.captureSourceSel
        && (ctrl_ff.pinFunc == PF_RISE) |-> capEvt == pinEdges[PIN_EXT].rise)
        else $error("Capture source selection not followed.");

    a_run_start: assert property (runRise |=> count_ff == CNT_ZERO)
        else $error("Counter not cleared on run start.");

    a_keep_running: assert property (
        run_ff && !clkSel_ff && capEvt && !runRise && (count_ff != periodTop)
        |=> count_ff == $past(count_ff) + CNT_ONE)
        else $error("Counter disturbed by a capture.");

    a_period_wrap: assert property (
        matchP && (ctrl_ff.opMode == MODE_CAPTURE)
        |=> count_ff == CNT_ZERO && status_ff[FLAG_P])
        else $error("Period match did not wrap and flag.");

    a_zero_period: assert property (
        run_ff && tick && !runRise && (period_ff == CNT_ZERO)
        && (ctrl_ff.opMode == MODE_CAPTURE) && (count_ff != CNT_MAX)
        |=> count_ff != CNT_ZERO)
        else $error("Counter wrapped early with zero period.");

    a_no_output: assert property (
        (ctrl_ff.opMode == MODE_CAPTURE) |=> !timerOut)
        else $error("Output driven in capture mode.");

    a_single_start: assert property (
        spMode && !run_ff && pinEdges[PIN_EXT].rise && !wrRun |=> run_ff)
        else $error("Single pulse not started by pin.");

    a_single_stop: assert property (
        spMode && matchA && !wrRun |=> !run_ff)
        else $error("Single pulse not ended by match A.");

    c_capture: cover property (capEvt ##2 irq);
    c_wrap:    cover property (matchP && (ctrl_ff.opMode == MODE_CAPTURE));
    c_pulse:   cover property (spMode && matchA);
    c_both:    cover property (capEvt && capEdge.fall);
endmodule : ptc_capture_timer

`default_nettype wire

/* verif/ptc_pulse_source.sv */
// Purpose: Model of the external signal source that drives the timer pins.
// Assumes: Pins idle low and change just after a rising clock edge.
// Notes: The bench calls pulse to make one high pulse on either pin.

`timescale 1ns/1ps
`default_nettype none

module ptc_pulse_source
(
    input  wire logic clk,
    output var logic  capturePin,
    output var logic  extClockPin
);
    initial
    begin
        capturePin  = 1'b0;
        extClockPin = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A pulse starts lead edges after the call and never lasts under two clocks.
    task automatic pulse(input logic onExt, input int lead, input int width);
        int w;
        w = (width < 2) ? 2 : width;
        repeat (lead) @(posedge clk);
        if (onExt)
            extClockPin <= 1'b1;
        else
            capturePin <= 1'b1;
        repeat (w) @(posedge clk);
        if (onExt)
            extClockPin <= 1'b0;
        else
            capturePin <= 1'b0;
    endtask : pulse
endmodule : ptc_pulse_source

`default_nettype wire

/* verif/periodic_timer_capture_pulse_tb_top.sv */
// Purpose: Self-checking bench for the capture timer.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes: The timer clock is internal except in the extTicks test, which selects the external clock pin.

`timescale 1ns/1ps
`default_nettype none

module periodic_timer_capture_pulse_tb_top;
    import ptc_pkg::*;
    localparam int LIMIT = 4000;
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata;
    logic              regWr;
    logic              regRd;
    logic [DATA_W-1:0] regRdata;
    logic              capturePin;
    logic              extClockPin;
    logic              timerOut;
    logic              irq;
    int                badCount;
    int                checked;
    int                cycles;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] r;
    logic [CNT_W-1:0]  e;
    ptc_ctrl_t         ctrl;

    ptc_capture_timer u_ptc_capture_timer
    (
        .clk         (clk),
        .rst         (rst),
        .regAddr     (regAddr),
        .regWdata    (regWdata),
        .regWr       (regWr),
        .regRd       (regRd),
        .regRdata    (regRdata),
        .capturePin  (capturePin),
        .extClockPin (extClockPin),
        .timerOut    (timerOut),
        .irq         (irq)
    );

    ptc_pulse_source u_ptc_pulse_source
    (
        .clk         (clk),
        .capturePin  (capturePin),
        .extClockPin (extClockPin)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    task automatic cmpReg(input string n, input logic [DATA_W-1:0] x, input logic [DATA_W-1:0] g);
        checked++;
        if (g !== x)
        begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask : cmpReg

    task automatic cmpBit(input string n, input logic x, input logic g);
        checked++;
        if (g !== x)
        begin
            badCount++;
            $display("MISMATCH %s expected %b seen %b", n, x, g);
        end
    endtask : cmpBit

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask : rd

    task automatic setCtrl(input ptc_mode_t m, input ptc_pinfunc_t pf, input logic src,
                           input logic outBits);
        ctrl = CTRL_RST;
        ctrl.opMode             = m;
        ctrl.pinFunc            = pf;
        ctrl.captureSourceSel   = src;
        ctrl.outputInitialLevel = outBits;
        ctrl.outputInvert       = outBits;
        ctrl.clearSourceSel     = outBits;
        wr(ADDR_CTRL1, {8'h00, ctrl});
    endtask : setCtrl

    // A pulse of six clocks starts on the edge that samples the counter read.
    task automatic capTest(input ptc_pinfunc_t pf, input logic src, input logic onExt,
                           input logic expCap, input logic atFall);
        setCtrl(MODE_CAPTURE, pf, src, 1'b1);
        wr(ADDR_COMPARE_CAPTURE_A, 16'h0000);
        rd(ADDR_STATUS, r);
        fork
            rd(ADDR_COUNT, v);
            u_ptc_pulse_source.pulse(onExt, 2, 6);
        join
        repeat (8) @(posedge clk);
        e = v[CNT_W-1:0] + 10'h003 + (atFall ? 10'h006 : 10'h000);
        if (!expCap)
            e = CNT_ZERO;
        cmpBit("irq", expCap, irq);
        cmpBit("timerOut", 1'b0, timerOut);
        rd(ADDR_COMPARE_CAPTURE_A, r);
        cmpReg("compare_capture_a", {6'h00, e}, r);
        rd(ADDR_STATUS, r);
        cmpBit("matchA", expCap, r[FLAG_A]);
    endtask : capTest

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            badCount++;
            give_verdict();
        end
    end

    initial
    begin
        rst      = 1'b1;
        regAddr  = '0;
        regWdata = '0;
        regWr    = 1'b0;
        regRd    = 1'b0;
        badCount = 0;
        checked  = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 9; a++)
        begin
            rd(4'(a), r);
            cmpReg("resetValue", 16'h0000, r);
        end
        wr(ADDR_MASK, 16'h0001);
        wr(ADDR_PERIOD, 16'h0000);
        setCtrl(MODE_CAPTURE, PF_RISE, 1'b0, 1'b1);
        wr(ADDR_RUN, 16'h0001);
        rd(ADDR_COUNT, v);
        repeat (998) @(posedge clk);
        rd(ADDR_COUNT, r);
        e = v[CNT_W-1:0] + 10'h3e8;
        cmpReg("fullRange", {6'h00, e}, r);
        capTest(PF_RISE, 1'b0, 1'b0, 1'b1, 1'b0);
        capTest(PF_FALL, 1'b0, 1'b0, 1'b1, 1'b1);
        capTest(PF_BOTH, 1'b0, 1'b0, 1'b1, 1'b1);
        capTest(PF_NONE, 1'b0, 1'b0, 1'b0, 1'b0);
        capTest(PF_RISE, 1'b1, 1'b0, 1'b0, 1'b0);
        capTest(PF_RISE, 1'b1, 1'b1, 1'b1, 1'b0);
        wr(ADDR_RUN, 16'h0000);
        rd(ADDR_COUNT, v);
        repeat (10) @(posedge clk);
        rd(ADDR_COUNT, r);
        cmpReg("stopped", v, r);
        wr(ADDR_MASK, 16'h0002);
        wr(ADDR_PERIOD, 16'h0014);
        wr(ADDR_RUN, 16'h0001);
        repeat (30) @(posedge clk);
        rd(ADDR_COUNT, v);
        cmpReg("periodPhase", 16'h0009, v);
        repeat (19) @(posedge clk);
        rd(ADDR_COUNT, r);
        cmpReg("periodWrap", v, r);
        cmpBit("irqPeriod", 1'b1, irq);
        rd(ADDR_STATUS, r);
        cmpBit("periodFlag", 1'b1, r[FLAG_P]);
        wr(ADDR_MASK, 16'h0000);
        repeat (25) @(posedge clk);
        cmpBit("irqMasked", 1'b0, irq);
        rd(ADDR_STATUS, r);
        cmpBit("periodFlag", 1'b1, r[FLAG_P]);
        setCtrl(MODE_CAPTURE, PF_NONE, 1'b0, 1'b0);
        wr(ADDR_RUN, 16'h0000);
        wr(ADDR_RUN, 16'h0003);
        repeat (3) u_ptc_pulse_source.pulse(1'b1, 2, 2);
        repeat (4) @(posedge clk);
        rd(ADDR_COUNT, r);
        cmpReg("extTicks", 16'h0003, r);
        wr(ADDR_RUN, 16'h0000);
        wr(ADDR_COMPARE_CAPTURE_A, 16'h00c8);
        setCtrl(MODE_PWM, PF_NONE, 1'b0, 1'b0);
        wr(ADDR_MASK, 16'h0001);
        rd(ADDR_STATUS, r);
        u_ptc_pulse_source.pulse(1'b1, 1, 3);
        repeat (20) @(posedge clk);
        rd(ADDR_RUN, r);
        cmpBit("runSet", 1'b1, r[BIT_RUN]);
        cmpBit("pulseOut", 1'b1, timerOut);
        repeat (250) @(posedge clk);
        rd(ADDR_RUN, r);
        cmpBit("runCleared", 1'b0, r[BIT_RUN]);
        cmpBit("pulseEnd", 1'b0, timerOut);
        rd(ADDR_STATUS, r);
        cmpBit("matchA", 1'b1, r[FLAG_A]);
        give_verdict();
    end
endmodule : periodic_timer_capture_pulse_tb_top

`default_nettype wire
